// ---- hdl/adcsq_pkg.sv ----
package adcsq_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int unsigned ADCSQ_MAX_CH   = 16;
  localparam int unsigned ADCSQ_ADDR_W   = 8;
  localparam int unsigned ADCSQ_DATA_W   = 32;
  localparam int unsigned ADCSQ_CHAN_W   = 4;
  localparam int unsigned ADCSQ_RESULT_W = 12;
  localparam int unsigned ADCSQ_RES10_W  = 10;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] ADCSQ_OFF_CTRL  = 8'h00;
  localparam logic [7:0] ADCSQ_OFF_DONE  = 8'h08;
  localparam logic [7:0] ADCSQ_OFF_SMASK = 8'h0C;
  localparam logic [7:0] ADCSQ_OFF_PMASK = 8'h10;
  localparam logic [7:0] ADCSQ_OFF_CFG   = 8'h14;
  localparam logic [7:0] ADCSQ_OFF_EVT   = 8'h18;
  localparam logic [7:0] ADCSQ_OFF_IMSK  = 8'h1C;
  localparam logic [7:0] ADCSQ_OFF_RES0  = 8'h40;

  // ==========================================================================
  // Field positions and values
  // ==========================================================================
  localparam int unsigned ADCSQ_CTRL_ONE_SHOT_BIT = 1;
  localparam int unsigned ADCSQ_CTRL_PERIODIC_BIT = 2;
  localparam int unsigned ADCSQ_EVT_ONE_SHOT_BIT  = 0;
  localparam int unsigned ADCSQ_EVT_PERIODIC_BIT  = 1;
  localparam int unsigned ADCSQ_EVT_W             = 2;
  localparam logic [1:0]  ADCSQ_RES_10BIT         = 2'h2;
  localparam logic [1:0]  ADCSQ_RES_12BIT         = 2'h3;
  localparam logic [1:0]  ADCSQ_RES_RESET         = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_REQ  = 2'b01,
    ADCSQ_WAIT = 2'b10
  } adcsq_state_t;

  typedef struct packed {
    logic                      req;
    logic [ADCSQ_CHAN_W-1:0]   chan;
    logic [1:0]                res;
  } adcsq_core_req_t;

  typedef struct packed {
    logic                      done;
    logic [ADCSQ_RESULT_W-1:0] data;
  } adcsq_core_rsp_t;

endpackage

// ---- hdl/adcsq_pick.sv ----
`timescale 1ns/1ns
module adcsq_pick #(
  parameter int unsigned NUM_CH = 16
) (
  input  wire logic [NUM_CH-1:0] pend,  // Channels still waiting in this pass
  output logic                   any,   // At least one channel waits
  output logic [3:0]             idx    // Lowest waiting channel
);
  // ==========================================================================
  // Lowest-set-bit search
  // ==========================================================================
  logic [NUM_CH:0] below;
  logic [3:0]      acc [NUM_CH+1];

  assign below[0] = 1'b0;
  assign acc[0]   = 4'h0;

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_bit
      assign below[i+1] = below[i] | pend[i];
      assign acc[i+1]   = acc[i] | ((pend[i] & ~below[i]) ? 4'(i) : 4'h0);
    end
  endgenerate

  assign any = below[NUM_CH];
  assign idx = acc[NUM_CH];
endmodule

// ---- hdl/adcsq_top.sv ----
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int unsigned NUM_CH = 16
) (
  input  wire logic                         REF_CLK,   // System clock, 50 MHz
  input  wire logic                         RST,       // Async reset, active high
  input  wire logic                         PSEL,      // APB select
  input  wire logic                         PENABLE,   // APB access phase
  input  wire logic                         PWRITE,    // APB direction
  input  wire logic [adcsq_pkg::ADCSQ_ADDR_W-1:0] PADDR,     // APB byte address
  input  wire logic [adcsq_pkg::ADCSQ_DATA_W-1:0] PWDATA,    // APB write data
  output logic      [adcsq_pkg::ADCSQ_DATA_W-1:0] PRDATA,    // APB read data
  output logic                              PREADY,    // APB ready
  output logic                              PSLVERR,   // APB error
  output logic                              IRQ,       // Interrupt, level high
  output adcsq_pkg::adcsq_core_req_t        CORE_REQ,  // Request to converter core
  input  wire adcsq_pkg::adcsq_core_rsp_t   CORE_RSP   // Answer from converter core
);
  import adcsq_pkg::*;

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  generate
    if (NUM_CH < 1 || NUM_CH > ADCSQ_MAX_CH) begin : g_bad_num_ch
      $error("NUM_CH must lie between 1 and 16");
    end
  endgenerate

  localparam logic [8:0] RES_END = 9'(ADCSQ_OFF_RES0) + 9'(4 * NUM_CH);

  // ==========================================================================
  // State
  // ==========================================================================
  adcsq_state_t                state_ff;
  adcsq_core_req_t             core_req_ff;
  logic [NUM_CH-1:0]           pending_ff;
  logic                        periodic_pass_ff;
  logic [NUM_CH-1:0]           done_ff;
  logic [NUM_CH-1:0]           smask_ff;
  logic [NUM_CH-1:0]           pmask_ff;
  logic                        one_shot_trig_ff;
  logic                        periodic_en_ff;
  logic [1:0]                  res_ff;
  logic [ADCSQ_EVT_W-1:0]      evt_ff;
  logic [ADCSQ_EVT_W-1:0]      imask_ff;
  logic [ADCSQ_RESULT_W-1:0]   result_ff [NUM_CH];
  logic [ADCSQ_DATA_W-1:0]     prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic                        irq_ff;

  logic                        pick_any;
  logic [3:0]                  pick_idx;
  logic                        setup;
  logic                        access;
  logic                        wr;
  logic                        is_result;
  logic [3:0]                  rd_ch;
  logic [ADCSQ_DATA_W-1:0]     rd_mux;
  logic                        rd_bad;
  logic                        start_single;
  logic                        start_periodic;
  logic                        conv_issue;
  logic                        conv_end;
  logic                        pass_end;
  logic [NUM_CH-1:0]           chan_onehot;
  logic [NUM_CH-1:0]           done_set;
  logic [NUM_CH-1:0]           done_clr;
  logic [ADCSQ_EVT_W-1:0]      evt_set;
  logic [ADCSQ_EVT_W-1:0]      evt_clr;
  logic [ADCSQ_RESULT_W-1:0]   new_result;

  adcsq_pick #(
    .NUM_CH (NUM_CH)
  ) u_pick (
    .pend (pending_ff),
    .any  (pick_any),
    .idx  (pick_idx)
  );

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign setup     = PSEL & ~PENABLE;
  assign access    = PSEL & PENABLE & pready_ff;
  assign wr        = access & PWRITE;
  assign is_result = ({1'b0, PADDR} >= 9'(ADCSQ_OFF_RES0)) && ({1'b0, PADDR} < RES_END)
                     && (PADDR[1:0] == 2'b00);
  assign rd_ch     = PADDR[5:2];

  always_comb begin
    rd_mux = '0;
    rd_bad = 1'b0;
    if (PADDR == ADCSQ_OFF_CTRL) begin
      rd_mux[ADCSQ_CTRL_ONE_SHOT_BIT] = one_shot_trig_ff;
      rd_mux[ADCSQ_CTRL_PERIODIC_BIT] = periodic_en_ff;
    end else if (PADDR == ADCSQ_OFF_DONE) begin
      rd_mux = 32'(done_ff);
    end else if (PADDR == ADCSQ_OFF_SMASK) begin
      rd_mux = 32'(smask_ff);
    end else if (PADDR == ADCSQ_OFF_PMASK) begin
      rd_mux = 32'(pmask_ff);
    end else if (PADDR == ADCSQ_OFF_CFG) begin
      rd_mux = 32'(res_ff);
    end else if (PADDR == ADCSQ_OFF_EVT) begin
      rd_mux = 32'(evt_ff);
    end else if (PADDR == ADCSQ_OFF_IMSK) begin
      rd_mux = 32'(imask_ff);
    end else if (is_result) begin
      rd_mux = 32'(result_ff[rd_ch]);
    end else begin
      rd_bad = 1'b1;
    end
  end

  // No wait state: the read mux gets the setup cycle and PRDATA stays a flop.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff  <= PWRITE ? '0 : rd_mux;
        pslverr_ff <= rd_bad;
      end
    end
  end

  // ==========================================================================
  // Control and configuration registers
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      smask_ff       <= '0;
      pmask_ff       <= '0;
      periodic_en_ff <= 1'b0;
      res_ff         <= ADCSQ_RES_RESET;
      imask_ff       <= '0;
    end else if (wr) begin
      if (PADDR == ADCSQ_OFF_CTRL) begin
        periodic_en_ff <= PWDATA[ADCSQ_CTRL_PERIODIC_BIT];
      end else if (PADDR == ADCSQ_OFF_SMASK) begin
        smask_ff <= PWDATA[NUM_CH-1:0];
      end else if (PADDR == ADCSQ_OFF_PMASK) begin
        pmask_ff <= PWDATA[NUM_CH-1:0];
      end else if (PADDR == ADCSQ_OFF_CFG) begin
        res_ff <= PWDATA[1:0];
      end else if (PADDR == ADCSQ_OFF_IMSK) begin
        imask_ff <= PWDATA[ADCSQ_EVT_W-1:0];
      end
    end
  end

  // A fresh write of 1 beats the self-clear, so a back-to-back request survives.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      one_shot_trig_ff <= 1'b0;
    end else if (wr && PADDR == ADCSQ_OFF_CTRL && PWDATA[ADCSQ_CTRL_ONE_SHOT_BIT]) begin
      one_shot_trig_ff <= 1'b1;
    end else if (start_single) begin
      one_shot_trig_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Pass sequencer
  // ==========================================================================
  assign start_single   = (state_ff == ADCSQ_IDLE) & one_shot_trig_ff;
  assign start_periodic = (state_ff == ADCSQ_IDLE) & ~one_shot_trig_ff & periodic_en_ff;
  assign conv_issue     = (state_ff == ADCSQ_REQ) & pick_any;
  assign pass_end       = (state_ff == ADCSQ_REQ) & ~pick_any;
  assign conv_end       = (state_ff == ADCSQ_WAIT) & CORE_RSP.done;
  assign chan_onehot    = NUM_CH'(1) << core_req_ff.chan;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_ff         <= ADCSQ_IDLE;
      pending_ff       <= '0;
      periodic_pass_ff <= 1'b0;
      core_req_ff      <= '0;
    end else begin
      core_req_ff.res <= res_ff;
      case (state_ff)
        ADCSQ_IDLE: begin
          if (start_single) begin
            pending_ff       <= smask_ff;
            periodic_pass_ff <= 1'b0;
            state_ff         <= ADCSQ_REQ;
          end else if (start_periodic) begin
            pending_ff       <= pmask_ff;
            periodic_pass_ff <= 1'b1;
            state_ff         <= ADCSQ_REQ;
          end
        end
        ADCSQ_REQ: begin
          if (pick_any) begin
            core_req_ff.req  <= 1'b1;
            core_req_ff.chan <= pick_idx;
            state_ff         <= ADCSQ_WAIT;
          end else begin
            state_ff <= ADCSQ_IDLE;
          end
        end
        ADCSQ_WAIT: begin
          if (CORE_RSP.done) begin
            core_req_ff.req <= 1'b0;
            pending_ff      <= pending_ff & ~chan_onehot;
            state_ff        <= ADCSQ_REQ;
          end
        end
        default: begin
          state_ff <= ADCSQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Results and completion flags
  // ==========================================================================
  assign new_result = (res_ff == ADCSQ_RES_10BIT) ?
                      {2'b00, CORE_RSP.data[ADCSQ_RES10_W-1:0]} : CORE_RSP.data;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result_ff[i] <= '0;
      end
    end else if (conv_end) begin
      result_ff[core_req_ff.chan] <= new_result;
    end
  end

  // A flag drops when its channel is requested again, so it never reads 1 mid-conversion.
  assign done_set = conv_end ? chan_onehot : '0;
  assign done_clr = ((wr && PADDR == ADCSQ_OFF_DONE) ? PWDATA[NUM_CH-1:0] : '0)
                    | (conv_issue ? (NUM_CH'(1) << pick_idx) : '0);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      done_ff <= '0;
    end else begin
      done_ff <= (done_ff & ~done_clr) | done_set;
    end
  end

  // ==========================================================================
  // Pass-done events and interrupt
  // ==========================================================================
  assign evt_set = pass_end ? (periodic_pass_ff ? 2'b10 : 2'b01) : 2'b00;
  // Only bits returned by this read are cleared, so a later event is kept.
  assign evt_clr = (access && !PWRITE && PADDR == ADCSQ_OFF_EVT) ?
                   prdata_ff[ADCSQ_EVT_W-1:0] : 2'b00;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      evt_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      evt_ff <= (evt_ff & ~evt_clr) | evt_set;
      irq_ff <= |(evt_ff & imask_ff);
    end
  end

  assign PRDATA   = prdata_ff;
  assign PREADY   = pready_ff;
  assign PSLVERR  = pslverr_ff;
  assign IRQ      = irq_ff;
  assign CORE_REQ = core_req_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_pass_end_single;
    pass_end && !periodic_pass_ff;
  endsequence

  sequence s_pass_end_periodic;
    pass_end && periodic_pass_ff;
  endsequence

  sequence s_w1c_write;
    wr && PADDR == ADCSQ_OFF_DONE && !conv_end;
  endsequence

  chk_flag_on_done: assert property (
    |(done_ff & ~$past(done_ff)) |-> $past(conv_end))
    else $error("Done flag rose without a finished conversion.");

  chk_w1c_clear: assert property (
    s_w1c_write |=> (done_ff & $past(PWDATA[NUM_CH-1:0])) == '0)
    else $error("Writing one did not clear the done flag.");

  chk_done_upper_zero: assert property (
    (setup && !PWRITE && PADDR == ADCSQ_OFF_DONE) |=> PRDATA[31:16] == 16'h0000)
    else $error("Reserved done-register bits read nonzero.");

  chk_single_pass: assert property (
    s_pass_end_single |=> evt_ff[ADCSQ_EVT_ONE_SHOT_BIT] && pending_ff == '0)
    else $error("One-shot pass end did not raise its flag.");

  chk_periodic_pass: assert property (
    s_pass_end_periodic |=> evt_ff[ADCSQ_EVT_PERIODIC_BIT] && state_ff == ADCSQ_IDLE)
    else $error("Periodic pass end did not raise its flag.");

  chk_single_mask: assert property (
    start_single |=> pending_ff == $past(smask_ff))
    else $error("One-shot pass does not follow the one-shot mask.");

  chk_periodic_mask: assert property (
    start_periodic |=> pending_ff == $past(pmask_ff) && periodic_pass_ff)
    else $error("Periodic pass does not follow the periodic mask.");

  chk_req_enabled: assert property (
    $rose(core_req_ff.req) |-> $past(pending_ff[pick_idx]) && core_req_ff.chan == $past(pick_idx))
    else $error("Converter asked for a channel not in the pass.");

  chk_trig_clear: assert property (
    (start_single && !wr) |=> !one_shot_trig_ff && state_ff == ADCSQ_REQ)
    else $error("One-shot trigger did not clear itself.");

  chk_res10_zero: assert property (
    (conv_end && res_ff == ADCSQ_RES_10BIT) |=> result_ff[$past(core_req_ff.chan)][11:10] == 2'b00)
    else $error("Ten-bit result has upper bits set.");

  chk_result_ready: assert property (
    conv_end |=> done_ff[$past(core_req_ff.chan)] &&
                 result_ff[$past(core_req_ff.chan)] == $past(new_result))
    else $error("Result word not in place when its flag set.");

  chk_result_upper: assert property (
    (setup && !PWRITE && is_result) |=> PRDATA[31:12] == 20'h00000 && PREADY)
    else $error("Result word upper bits read nonzero.");

endmodule

// ---- sim/adcsq_core_model.sv ----
`timescale 1ns/1ns
module adcsq_core_model (
  input  wire logic                       clk,   // System clock
  input  wire logic                       rst,   // Reset, active high
  input  wire adcsq_pkg::adcsq_core_req_t req,   // Request from the sequencer
  output adcsq_pkg::adcsq_core_rsp_t      rsp    // Answer to the sequencer
);
  import adcsq_pkg::*;

  // ==========================================================================
  // Behavioural converter core
  // ==========================================================================
  int                        max_wait = 1;
  int                        order [$];
  logic [ADCSQ_RESULT_W-1:0] last_data [ADCSQ_MAX_CH];
  logic                      busy_ff;
  int                        cnt_ff;
  logic [ADCSQ_CHAN_W-1:0]   chan_ff;
  logic [ADCSQ_RESULT_W-1:0] nxt_data;

  // The data lines toggle outside a done pulse, so a stale result never looks valid.
  always @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'h0;
      rsp     <= '0;
    end else if (rsp.done) begin
      rsp.done <= 1'h0;
      rsp.data <= ~rsp.data;
    end else if (busy_ff && cnt_ff <= 1) begin
      nxt_data = ADCSQ_RESULT_W'($urandom);
      rsp.done <= 1'h1;
      rsp.data <= nxt_data;
      last_data[chan_ff] <= nxt_data;
      order.push_back(int'(chan_ff));
      busy_ff <= 1'h0;
    end else begin
      rsp.data <= ~rsp.data;
      if (busy_ff) begin
        cnt_ff <= cnt_ff - 1;
      end else if (req.req === 1'h1) begin
        busy_ff <= 1'h1;
        chan_ff <= req.chan;
        cnt_ff  <= $urandom_range(max_wait, 1);
      end
    end
  end
endmodule

// ---- sim/tb_adc_channel_sequencer_status.sv ----
`timescale 1ns/1ns
module tb_adc_channel_sequencer_status;
  import adcsq_pkg::*;

  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic                    ref_clk = 1'h0;
  logic                    rst     = 1'h1;
  logic                    psel    = 1'h0;
  logic                    penable = 1'h0;
  logic                    pwrite  = 1'h0;
  logic [ADCSQ_ADDR_W-1:0] paddr   = '0;
  logic [ADCSQ_DATA_W-1:0] pwdata  = '0;
  logic [ADCSQ_DATA_W-1:0] prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  adcsq_core_req_t         core_req;
  adcsq_core_rsp_t         core_rsp;
  int                      err_count = 0;
  int                      samples_checked = 0;
  logic [31:0]             rd;
  logic                    er;

  always #10 ref_clk = ~ref_clk;

  adcsq_top #(.NUM_CH(16)) dut (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .CORE_REQ(core_req), .CORE_RSP(core_rsp));

  adcsq_core_model model (.clk(ref_clk), .rst(rst), .req(core_req), .rsp(core_rsp));

  // ==========================================================================
  // Tasks and expectations
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole 32-bit words only, so result reads are always coherent.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1);
    check("pready_wait", 32'(n), 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic wait_pass(input bit use_irq, input int bitn);
    forever begin
      if (use_irq) begin
        @(posedge ref_clk);
        if (irq === 1'h1) break;
      end else begin
        xfer(ADCSQ_OFF_EVT, 1'h0, 32'h0);
        if (rd[bitn] === 1'h1) break;
      end
    end
    if (use_irq) xfer(ADCSQ_OFF_EVT, 1'h0, 32'h0);
  endtask

  task automatic wait_idle();
    int q;
    q = 0;
    while (q < 4) begin
      @(posedge ref_clk);
      q = (core_req.req === 1'h0) ? q + 1 : 0;
    end
  endtask

  function automatic logic [31:0] exp_res(input int ch, input bit ten);
    logic [11:0] d;
    d = model.last_data[ch];
    return ten ? {22'h0, d[9:0]} : {20'h0, d};
  endfunction

  task automatic check_results(input logic [15:0] m, input bit ten);
    for (int k = 0; k < 16; k++) begin
      if (m[k]) begin
        xfer(ADCSQ_OFF_RES0 + 8'(4 * k), 1'h0, 32'h0);
        check("result", rd, exp_res(k, ten));
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_count++;
    test_done();
  end

  initial begin
    logic [15:0] m;
    logic [31:0] w;
    w = $urandom(53);
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    xfer(ADCSQ_OFF_DONE, 1'h0, 32'h0);
    check("done_reset", rd, 32'h0);
    xfer(ADCSQ_OFF_SMASK, 1'h0, 32'h0);
    check("smask_reset", rd, 32'h0);
    xfer(ADCSQ_OFF_PMASK, 1'h0, 32'h0);
    check("pmask_reset", rd, 32'h0);
    xfer(ADCSQ_OFF_SMASK, 1'h1, 32'hFFFFFFFF);
    xfer(ADCSQ_OFF_SMASK, 1'h0, 32'h0);
    check("smask_rw", rd, 32'h0000FFFF);
    xfer(ADCSQ_OFF_PMASK, 1'h1, 32'hFFFFFFFF);
    xfer(ADCSQ_OFF_PMASK, 1'h0, 32'h0);
    check("pmask_rw", rd, 32'h0000FFFF);
    xfer(ADCSQ_OFF_PMASK, 1'h1, 32'h0);
    xfer(8'h3C, 1'h0, 32'h0);
    check("unmapped_err", 32'(er), 32'h1);
    $display("Test registers finished");
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8001 : (i == 2) ? 16'h0000 : 16'($urandom);
      model.max_wait = (i % 2) ? 7 : 1;
      xfer(ADCSQ_OFF_CFG, 1'h1, (i == 3) ? 32'(ADCSQ_RES_10BIT) : 32'(ADCSQ_RES_12BIT));
      xfer(ADCSQ_OFF_IMSK, 1'h1, (i == 4) ? 32'h0 : 32'h3);
      xfer(ADCSQ_OFF_SMASK, 1'h1, {16'h0, m});
      model.order.delete();
      xfer(ADCSQ_OFF_CTRL, 1'h1, 32'h1 << ADCSQ_CTRL_ONE_SHOT_BIT);
      wait_pass(i != 4, ADCSQ_EVT_ONE_SHOT_BIT);
      check("evt_one_shot", rd, 32'h1);
      xfer(ADCSQ_OFF_EVT, 1'h0, 32'h0);
      check("evt_cleared", rd, 32'h0);
      @(posedge ref_clk);
      check("irq_low", 32'(irq), 32'h0);
      xfer(ADCSQ_OFF_CTRL, 1'h0, 32'h0);
      check("trigger_clear", 32'(rd[ADCSQ_CTRL_ONE_SHOT_BIT]), 32'h0);
      xfer(ADCSQ_OFF_DONE, 1'h0, 32'h0);
      check("done_flags", rd, {16'h0, m});
      for (int k = 0; k < 16; k++) begin
        if (m[k]) check("order", 32'(model.order.pop_front()), 32'(k));
      end
      check("order_len", 32'(model.order.size()), 32'h0);
      check_results(m, i == 3);
      if (i == 0) begin
        xfer(ADCSQ_OFF_RES0, 1'h1, ~exp_res(0, 1'h0));
        xfer(ADCSQ_OFF_RES0, 1'h0, 32'h0);
        check("result_ro", rd, exp_res(0, 1'h0));
      end
      w = $urandom;
      xfer(ADCSQ_OFF_DONE, 1'h1, w);
      xfer(ADCSQ_OFF_DONE, 1'h0, 32'h0);
      check("done_w1c", rd, {16'h0, m & ~w[15:0]});
      xfer(ADCSQ_OFF_DONE, 1'h1, 32'h0000FFFF);
      $display("Test one-shot pass %0d finished", i);
    end
    m = 16'($urandom) | 16'h0001;
    xfer(ADCSQ_OFF_IMSK, 1'h1, 32'h3);
    xfer(ADCSQ_OFF_PMASK, 1'h1, {16'h0, m});
    xfer(ADCSQ_OFF_CTRL, 1'h1, 32'h1 << ADCSQ_CTRL_PERIODIC_BIT);
    wait_pass(1'h1, ADCSQ_EVT_PERIODIC_BIT);
    check("evt_periodic", rd, 32'h2);
    xfer(ADCSQ_OFF_CTRL, 1'h1, 32'h0);
    wait_idle();
    xfer(ADCSQ_OFF_DONE, 1'h0, 32'h0);
    check("done_periodic", rd, {16'h0, m});
    check_results(m, 1'h0);
    $display("Test periodic passes finished");
    test_done();
  end
endmodule
